//--- pkg/t3_mframe_pkg.sv
package t3_mframe_pkg;
	// ==========================================================
	// frame geometry
	localparam int BLOCK_PAYLOAD = 84;
	localparam int TRIBS = 7;
	localparam logic [6:0] POS_RST = 7'h00;
	localparam logic [6:0] POS_LAST = 7'h54;
	localparam logic [6:0] POS_FIRST_PAY = 7'h01;
	localparam logic [2:0] BLK_RST = 3'h0;
	localparam logic [2:0] BLK_LAST = 3'h7;
	localparam logic [2:0] SUB_RST = 3'h0;
	localparam logic [2:0] SUB_LAST = 3'h6;
	localparam logic [2:0] TRIB_RST = 3'h0;
	localparam logic [2:0] TRIB_LAST = 3'h6;

	// ==========================================================
	// overhead slot of each block within a subframe
	typedef enum logic [2:0] {
		OVH_LEAD = 3'b000,
		OVH_F1 = 3'b001,
		OVH_C1 = 3'b010,
		OVH_F2 = 3'b011,
		OVH_C2 = 3'b100,
		OVH_F3 = 3'b101,
		OVH_C3 = 3'b110,
		OVH_F4 = 3'b111
	} ovh_t;

	// subframes whose lead bit is X2, parity or multiframe alignment
	localparam logic [2:0] SUB_X2 = 3'h1;
	localparam logic [2:0] SUB_P1 = 3'h2;
	localparam logic [2:0] SUB_P2 = 3'h3;
	localparam logic [2:0] SUB_M1 = 3'h4;
	localparam logic [2:0] SUB_M2 = 3'h5;
	localparam logic [2:0] SUB_M3 = 3'h6;

	// ==========================================================
	// fixed overhead values
	localparam logic F1_VAL = 1'b1;
	localparam logic F2_VAL = 1'b0;
	localparam logic F3_VAL = 1'b0;
	localparam logic F4_VAL = 1'b1;
	localparam logic M1_VAL = 1'b0;
	localparam logic M2_VAL = 1'b1;
	localparam logic M3_VAL = 1'b0;
	localparam logic STUFF_FILL = 1'b1;
	localparam logic UNDERRUN_FILL = 1'b1;
	localparam logic X_RST = 1'b0;
	localparam logic PAR_RST = 1'b0;
	localparam logic [6:0] STUFF_RST = 7'h00;

	// ==========================================================
	// line buffer shape: bit 0 line data, bit 1 frame start
	localparam int FIFO_WIDTH = 2;
	localparam int FIFO_DEPTH = 4;
endpackage

//--- pkg/bit_stream_if.sv
`timescale 1ns/10ps
interface bit_stream_if #(
	parameter int WIDTH = 2
);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

//--- core/stream_fifo.sv
`timescale 1ns/10ps
module stream_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// fill and drain sides
	bit_stream_if.snk wr,
	bit_stream_if.src rd
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_r;
	logic [PW-1:0] rptr_r;
	logic [CW-1:0] cnt_r;

	// ==========================================================
	// pointer wrap, generic so depth need not be a power of two
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
	endfunction

	wire do_wr = wr.valid && wr.ready;
	wire do_rd = rd.valid && rd.ready;

	// flags straight from the count, so full and empty never lie
	assign wr.ready = (cnt_r != FULL_CNT);
	assign rd.valid = (cnt_r != '0);
	assign rd.data = mem[rptr_r];

	// storage has no reset; only valid words are ever read
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wptr_r] <= wr.data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_wr) wptr_r <= ptr_inc(wptr_r);
			if (do_rd) rptr_r <= ptr_inc(rptr_r);
			if (do_wr && !do_rd) cnt_r <= CW'(cnt_r + 1'b1);
			else if (do_rd && !do_wr) cnt_r <= CW'(cnt_r - 1'b1);
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (!nrst)
		cnt_r <= FULL_CNT) else $error("fifo count above depth");
endmodule

//--- core/t3_mframe_formatter.sv
`timescale 1ns/10ps
// Overview of operation
// - subframe is eight blocks, each one overhead bit then 84 payload bits
// - subframe lead bits are X1 X2 P1 P2 M1 M2 M3, M bits 0 1 0
// - framing bits F1=1 F2=0 F3=0 F4=1 in every subframe
// - stuff slot is payload bit n of the last block of subframe n
// - each frame starts with X1 then the rest in frame order
// - payload bits interleave tributaries 1 to 7, twelve each per block
// - stuff slot carries tributary data when C bits zero, stuff when one
// - P1 and P2 both carry parity of previous frame payload
// - X1 equals X2, zero while receiver out of sync or AIS
module t3_mframe_formatter (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// tributary side
	input wire logic [6:0] trib_bit,
	input wire logic [6:0] trib_valid,
	output logic [6:0] trib_ready,
	input wire logic [6:0] stuff_req,
	output logic underrun,
	// local receive framer status
	input wire logic rx_oof,
	input wire logic rx_ais,
	// line side
	output logic line_bit,
	output logic line_sof,
	output logic line_valid,
	input wire logic line_ready
);
	bit_stream_if #(.WIDTH(t3_mframe_pkg::FIFO_WIDTH)) tx_in();
	bit_stream_if #(.WIDTH(t3_mframe_pkg::FIFO_WIDTH)) tx_out();

	logic [6:0] pos_r;
	logic [6:0] pos_nxt;
	logic [2:0] blk_r;
	logic [2:0] blk_nxt;
	logic [2:0] sub_r;
	logic [2:0] sub_nxt;
	logic [2:0] trib_r;
	logic [2:0] trib_nxt;
	logic [6:0] stuff_r;
	logic run_r;
	logic x_val_r;
	logic par_acc_r;
	logic par_prev_r;
	logic underrun_r;

	// ==========================================================
	// one-hot tributary select
	function automatic logic [6:0] trib_hot(input logic [2:0] t);
		trib_hot = 7'(7'h01 << t);
	endfunction

	// ==========================================================
	// position decode
	wire push = tx_in.valid && tx_in.ready;
	wire is_ovh = (pos_r == t3_mframe_pkg::POS_RST);
	wire pos_end = (pos_r == t3_mframe_pkg::POS_LAST);
	wire blk_end = (blk_r == t3_mframe_pkg::BLK_LAST);
	wire sub_end = (sub_r == t3_mframe_pkg::SUB_LAST);
	wire frame_end = pos_end && blk_end && sub_end;
	wire [6:0] stuff_pos = 7'({4'h0, sub_r} + 7'h01);
	wire stuff_slot = (blk_r == t3_mframe_pkg::OVH_F4) &&
		(pos_r == stuff_pos);
	wire cur_stuff = stuff_r[sub_r];
	wire do_stuff = stuff_slot && cur_stuff;
	wire take = push && !is_ovh && !do_stuff;
	wire trib_ok = trib_valid[trib_r];
	wire sof = is_ovh && (blk_r == t3_mframe_pkg::BLK_RST) &&
		(sub_r == t3_mframe_pkg::SUB_RST);

	// ==========================================================
	// lead bit of each subframe
	wire is_par_sub = (sub_r == t3_mframe_pkg::SUB_P1) ||
		(sub_r == t3_mframe_pkg::SUB_P2);
	wire lead_bit = is_par_sub ? par_prev_r :
		(sub_r == t3_mframe_pkg::SUB_M1) ? t3_mframe_pkg::M1_VAL :
		(sub_r == t3_mframe_pkg::SUB_M2) ? t3_mframe_pkg::M2_VAL :
		(sub_r == t3_mframe_pkg::SUB_M3) ? t3_mframe_pkg::M3_VAL :
		x_val_r;

	// overhead bit per block slot, C bits repeat the stuff decision
	wire is_c = (blk_r == t3_mframe_pkg::OVH_C1) ||
		(blk_r == t3_mframe_pkg::OVH_C2) ||
		(blk_r == t3_mframe_pkg::OVH_C3);
	wire ovh_bit = (blk_r == t3_mframe_pkg::OVH_LEAD) ? lead_bit :
		(blk_r == t3_mframe_pkg::OVH_F1) ? t3_mframe_pkg::F1_VAL :
		(blk_r == t3_mframe_pkg::OVH_F2) ? t3_mframe_pkg::F2_VAL :
		(blk_r == t3_mframe_pkg::OVH_F3) ? t3_mframe_pkg::F3_VAL :
		is_c ? cur_stuff :
		t3_mframe_pkg::F4_VAL;

	// payload: starved tributary sends fill rather than stalling line
	wire pay_bit = do_stuff ? t3_mframe_pkg::STUFF_FILL :
		trib_ok ? trib_bit[trib_r] : t3_mframe_pkg::UNDERRUN_FILL;
	wire tx_bit = is_ovh ? ovh_bit : pay_bit;

	// ==========================================================
	// buffer toward the line; a stalled line stalls the framer
	assign tx_in.valid = run_r;
	assign tx_in.data = {sof, tx_bit};
	assign tx_out.ready = line_ready;
	assign line_bit = tx_out.data[0];
	assign line_sof = tx_out.data[1];
	assign line_valid = tx_out.valid;
	assign trib_ready = take ? trib_hot(trib_r) : 7'h00;
	assign underrun = underrun_r;

	stream_fifo #(
		.WIDTH(t3_mframe_pkg::FIFO_WIDTH),
		.DEPTH(t3_mframe_pkg::FIFO_DEPTH)
	) line_buf (
		.clk(clk),
		.nrst(nrst),
		.wr(tx_in),
		.rd(tx_out)
	);

	// ==========================================================
	// frame counters
	assign pos_nxt = pos_end ? t3_mframe_pkg::POS_RST :
		7'(pos_r + 7'h01);
	assign blk_nxt = !pos_end ? blk_r :
		blk_end ? t3_mframe_pkg::BLK_RST : 3'(blk_r + 3'h1);
	assign sub_nxt = !(pos_end && blk_end) ? sub_r :
		sub_end ? t3_mframe_pkg::SUB_RST : 3'(sub_r + 3'h1);
	// tributary index runs 0..6 from the first payload bit of a block
	assign trib_nxt = is_ovh ? t3_mframe_pkg::TRIB_RST :
		(trib_r == t3_mframe_pkg::TRIB_LAST) ? t3_mframe_pkg::TRIB_RST :
		3'(trib_r + 3'h1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos_r <= t3_mframe_pkg::POS_RST;
			blk_r <= t3_mframe_pkg::BLK_RST;
			sub_r <= t3_mframe_pkg::SUB_RST;
			trib_r <= t3_mframe_pkg::TRIB_RST;
			run_r <= 1'b0;
		end else begin
			run_r <= 1'b1;
			if (push) begin
				pos_r <= pos_nxt;
				blk_r <= blk_nxt;
				sub_r <= sub_nxt;
				trib_r <= trib_nxt;
			end
		end
	end

	// ==========================================================
	// stuff request sampled at each subframe lead bit so all three
	// C bits and the stuff slot agree even if the request moves
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stuff_r <= t3_mframe_pkg::STUFF_RST;
		end else if (push && is_ovh &&
			blk_r == t3_mframe_pkg::OVH_LEAD) begin
			stuff_r[sub_r] <= stuff_req[sub_r];
		end
	end

	// ==========================================================
	// parity and alarm, both taken on the last bit of a frame so
	// the whole next frame, X1 through P2, sees one stable value
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			par_acc_r <= t3_mframe_pkg::PAR_RST;
			par_prev_r <= t3_mframe_pkg::PAR_RST;
			x_val_r <= t3_mframe_pkg::X_RST;
		end else if (push && frame_end) begin
			par_prev_r <= par_acc_r ^ tx_bit;
			par_acc_r <= t3_mframe_pkg::PAR_RST;
			x_val_r <= !(rx_oof || rx_ais);
		end else if (push && !is_ovh) begin
			par_acc_r <= par_acc_r ^ tx_bit;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) underrun_r <= 1'b0;
		else underrun_r <= take && !trib_ok;
	end

	// ==========================================================
	// checks
	a_block_len: assert property (@(posedge clk) disable iff (!nrst)
		push && pos_end |=> is_ovh && blk_r == $past(blk_nxt))
		else $error("block length not 85 bits");
	a_m_bits: assert property (@(posedge clk) disable iff (!nrst)
		push && is_ovh && blk_r == 3'h0 && sub_r >= 3'h4 |->
		tx_bit == (sub_r == 3'h5))
		else $error("M bit value wrong");
	a_f_bits: assert property (@(posedge clk) disable iff (!nrst)
		push && is_ovh && blk_r[0] |->
		tx_bit == (blk_r == 3'h1 || blk_r == 3'h7))
		else $error("F bit value wrong");
	a_stuff_slot: assert property (@(posedge clk) disable iff (!nrst)
		push && blk_r == 3'h7 && pos_r == stuff_pos && cur_stuff |->
		trib_ready == 7'h00 && tx_bit == 1'b1)
		else $error("stuff slot consumed tributary data");
	a_frame_start: assert property (@(posedge clk) disable iff (!nrst)
		push && frame_end |=> sof)
		else $error("frame does not restart at X1");
	a_interleave: assert property (@(posedge clk) disable iff (!nrst)
		push && pos_r == 7'h08 && !do_stuff |-> trib_ready == 7'h01)
		else $error("tributary interleave out of order");
	a_c_bits: assert property (@(posedge clk) disable iff (!nrst)
		push && is_ovh && blk_r == 3'h4 |->
		tx_bit == stuff_r[sub_r] && $stable(stuff_r[sub_r]))
		else $error("C bit disagrees with stuff decision");
	a_par_keep: assert property (@(posedge clk) disable iff (!nrst)
		push && frame_end |=> par_prev_r == $past(par_acc_r ^ tx_bit))
		else $error("frame parity not kept");
	a_par_send: assert property (@(posedge clk) disable iff (!nrst)
		push && is_ovh && blk_r == 3'h0 && is_par_sub |->
		tx_bit == par_prev_r)
		else $error("P bit not previous parity");
	a_x_alarm: assert property (@(posedge clk) disable iff (!nrst)
		push && frame_end && (rx_oof || rx_ais) |=>
		!x_val_r && !tx_bit)
		else $error("X bit not zero under alarm");
	a_x_equal: assert property (@(posedge clk) disable iff (!nrst)
		push && is_ovh && blk_r == 3'h0 && sub_r == t3_mframe_pkg::SUB_X2
		|-> tx_bit == x_val_r && $stable(x_val_r))
		else $error("X2 differs from X1");
endmodule

//--- test/line_sink.sv
`timescale 1ns/10ps
// ==========================================================
// line side receiver model, refuses one bit in four when slow
module line_sink (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// line side
	input wire logic line_valid,
	output logic line_ready,
	// stall control from the bench
	input wire logic slow
);
	logic [1:0] cnt_r;
	// free counter paces the stalls so the buffer fills up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end
	// bits are taken strictly in arrival order, whole frames
	assign line_ready = !(slow && cnt_r == 2'h3);
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic clk, nrst, slow, par;
	logic [6:0] trib_bit, trib_valid, trib_ready, stuff_req;
	logic underrun, rx_oof, rx_ais, line_bit, line_sof, line_valid, line_ready;
	int n_mismatch, compares, n_under;
	// ==========================================================
	// design and line model
	t3_mframe_formatter DUT (.clk(clk), .nrst(nrst), .trib_bit(trib_bit),
		.trib_valid(trib_valid), .trib_ready(trib_ready),
		.stuff_req(stuff_req), .underrun(underrun), .rx_oof(rx_oof),
		.rx_ais(rx_ais), .line_bit(line_bit), .line_sof(line_sof),
		.line_valid(line_valid), .line_ready(line_ready));
	line_sink sink (.clk(clk), .nrst(nrst), .line_valid(line_valid),
		.line_ready(line_ready), .slow(slow));
	// clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// underrun pulses are only counted, their exact spot is not defined
	always @(posedge clk) begin
		if (underrun === 1'b1) n_under++;
	end
	// ==========================================================
	// compare and closing tasks
	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// waits, bounded, for the next bit the line takes; looks at the
	// falling edge where outputs are settled, then lets the taking
	// rising edge pass so no read races the edge that launches data
	task automatic get_bit(output logic d, output logic sf);
		int w;
		w = 0;
		do begin
			@(negedge clk);
			w++;
		end while (!(line_valid === 1'b1 && line_ready === 1'b1) && w < 20);
		if (w >= 20) n_mismatch++;
		d = line_bit;
		sf = line_sof;
		@(posedge clk);
	endtask
	// ==========================================================
	// one whole frame; status set here is latched at its last bit
	task automatic check_frame(input logic x, input logic oof,
		input logic ais, input logic skip_b0);
		logic d, sf, p;
		logic [6:0] lead;
		int t;
		p = 1'h0;
		lead = {3'h2, par, par, x, x};
		rx_oof <= oof;
		rx_ais <= ais;
		for (int s = 0; s < 7; s++) begin
			for (int b = 0; b < 8; b++) begin
				for (int k = 0; k < 85; k++) begin
					get_bit(d, sf);
					chk(sf, s == 0 && b == 0 && k == 0);
					if (k == 0 && b == 0) begin
						chk(d, lead[s]);
					end else if (k == 0) begin
						chk(d, b[0] ? 1'((4'h9 >> (b / 2)) & 4'h1) :
							stuff_req[s]);
					end else begin
						t = (k - 1) % 7;
						p ^= d;
						if (b == 7 && k == s + 1 && stuff_req[s]) begin
							chk(d, 1'h1);
						end else if (!(skip_b0 && b == 0 && t == 2)) begin
							chk(d, trib_valid[t] ? trib_bit[t] : 1'h1);
						end
					end
				end
			end
		end
		par = p;
	endtask
	// ==========================================================
	// scenarios
	task automatic scn_reset;
		repeat (8) @(posedge clk);
		chk(trib_ready === 7'h00 && line_valid === 1'h0, 1'h1);
		chk(underrun, 1'h0);
		nrst <= 1'h1;
	endtask
	// alarm bit follows status one frame late; slow line from frame 3
	task automatic scn_frames;
		check_frame(1'h0, 1'h1, 1'h0, 1'h0);
		check_frame(1'h0, 1'h0, 1'h0, 1'h0);
		slow <= 1'h1;
		check_frame(1'h1, 1'h0, 1'h1, 1'h0);
		chk_cnt(n_under, 0);
	endtask
	// tributary 3 starves: fill bits go out, underrun pulses
	task automatic scn_underrun;
		trib_valid <= 7'h7B;
		check_frame(1'h0, 1'h0, 1'h0, 1'h1);
		chk_cnt(n_under > 0, 1);
		trib_valid <= 7'h7F;
	endtask
	initial begin
		n_mismatch = 0;
		compares = 0;
		n_under = 0;
		par = 1'h0;
		nrst = 1'h0;
		slow = 1'h0;
		trib_bit = 7'h2A;
		trib_valid = 7'h7F;
		stuff_req = 7'h55;
		rx_oof = 1'h1;
		rx_ais = 1'h0;
		scn_reset;
		scn_frames;
		scn_underrun;
		end_sim;
	end
	// four frames with stalls take about 22000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end
endmodule
